// *** logic/wmc_pkg.sv ***
// Purpose: constants for the watchdog and memory configuration decode block
// Assumes: 14-bit configuration words, Avalon-MM register window with 32-bit data
// Notes: byte offsets are word aligned; unimplemented word bits read as one
// Function
// - pick the watchdog clock source from the three-bit field; 111 means software picks.
// - window codes 000-101 fix the closed window; no software change, keyed access needed.
// - window codes 110 and 111 load runtime window 111, software may change it, no key.
// - mode 11 always runs, 10 runs awake only, 00 off; software enable ignored.
// - mode 01 runs the watchdog according to the software enable bit.
// - period codes 00000-10010 load prescaler with the same code, locked from software.
// - period codes 10011-11110 load the same code, fixed 1:32, locked from software.
// - period code 11111 loads 01011 at reset and lets software change the prescaler.
// - every unimplemented bit of both configuration words reads as one.
// - low-voltage programming bit set forces master clear function, ignoring its enable.
// - a clear of the low-voltage programming bit during low-voltage programming is rejected.
// - storage area write protection active when its bit is 0 and the area is enabled.
// - configuration region write protected while bit 9 is 0.
// - boot block write protection active when its bit is 0 and the boot block is enabled.
// - application block write protected while bit 7 is 0.
// - storage area partition present while bit 4 is 0.
// - boot block exists while bit 3 is 0, otherwise its size is zero.
// - boot size field used and writable only as its enable allows.
// - boot size codes 111,110,101,100 give 512,1024,2048,4096 words.
// - boot block never exceeds half of user program memory.
// - protection and enable bits are sticky; only bulk erase returns them to one.
package wmc_pkg;
   localparam int CFG_W = 14;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int BOOT_W = 17;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_WD_CFG = 5'h00;
   localparam logic [4:0] OFS_MEM_CFG = 5'h04;
   localparam logic [4:0] OFS_CTRL = 5'h08;
   localparam logic [4:0] OFS_WINDOW = 5'h0c;
   localparam logic [4:0] OFS_PRESCALE = 5'h10;
   localparam logic [4:0] OFS_STATUS = 5'h14;
   localparam logic [4:0] OFS_BOOT = 5'h18;
   // ----------------------------------------------------------------
   // watchdog word fields
   // ----------------------------------------------------------------
   localparam int WD_CS_LSB = 11;
   localparam int WD_WS_LSB = 8;
   localparam int WD_MODE_LSB = 5;
   localparam int WD_PS_LSB = 0;
   localparam logic [13:0] WD_UNIMP_MASK = 14'h0080;
   localparam logic [2:0] CS_SOFTWARE = 3'h7;
   localparam logic [2:0] WS_OPEN_FULL = 3'h7;
   localparam logic [2:0] WS_FIRST_SW = 3'h6;
   localparam logic [1:0] MODE_ALWAYS = 2'h3;
   localparam logic [1:0] MODE_AWAKE = 2'h2;
   localparam logic [1:0] MODE_SOFTWARE = 2'h1;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [4:0] PS_AUTO = 5'h1f;
   localparam logic [4:0] PS_AUTO_LOAD = 5'h0b;
   // ----------------------------------------------------------------
   // memory word fields
   // ----------------------------------------------------------------
   localparam int MEM_LVP = 13;
   localparam int MEM_SAF_WP = 11;
   localparam int MEM_CFG_WP = 9;
   localparam int MEM_BOOT_WP = 8;
   localparam int MEM_APP_WP = 7;
   localparam int MEM_SAF_EN_N = 4;
   localparam int MEM_BOOT_EN_N = 3;
   localparam int MEM_BSIZE_LSB = 0;
   localparam logic [13:0] MEM_UNIMP_MASK = 14'h1460;
   localparam logic [13:0] MEM_STICKY_MASK = 14'h0b98;
   localparam logic [13:0] MEM_SIZE_MASK = 14'h0007;
   localparam logic [13:0] ERASED_WORD = 14'h3fff;
   localparam logic [BOOT_W-1:0] BOOT_MIN_WORDS = 17'h00200;
   // ----------------------------------------------------------------
   // control and status bit positions
   // ----------------------------------------------------------------
   localparam int CTRL_SW_EN = 0;
   localparam int CTRL_ERASE = 1;
   localparam int CTRL_CS_LSB = 4;
   localparam int ST_RUN = 0;
   localparam int ST_LVP_ACT = 1;
   localparam int ST_SLEEP = 2;
   localparam int ST_KEYED = 3;
   localparam int ST_PS_SW = 4;
   localparam int ST_WS_SW = 5;
endpackage

// *** logic/wmc_decode.sv ***
// Purpose: latch and decode the watchdog and memory configuration words
// Assumes: nonvolatile words are stable on the same clock at reset release
// Notes: registers reached over Avalon-MM, one wait cycle per access
`timescale 1ns/1ns
module wmc_decode #(
   parameter int USER_MEM_WORDS = 8192
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // nonvolatile configuration words
   input wire logic [13:0] nv_wd_word,
   input wire logic [13:0] nv_mem_word,
   // pins from outside the clock domain
   input wire logic sleep_pin,
   input wire logic lvp_session_pin,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // decoded watchdog controls
   output logic wd_run,
   output logic [2:0] wd_clock_source_sel,
   output logic [2:0] wd_runtime_window,
   output logic [4:0] wd_runtime_prescale,
   output logic wd_keyed_access_req,
   // decoded memory controls
   output logic low_voltage_prog_enable,
   output logic master_clear_forced,
   output logic storage_area_present,
   output logic storage_area_wp,
   output logic config_region_wp,
   output logic boot_region_wp,
   output logic app_region_wp,
   output logic [16:0] boot_region_words
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   localparam logic [16:0] HALF_WORDS = 17'(USER_MEM_WORDS / 2);

   // size code 111 is the smallest block; each step down doubles it, up to half of user memory
   function automatic logic [16:0] boot_size(input logic [2:0] code);
      logic [16:0] raw;
      raw = wmc_pkg::BOOT_MIN_WORDS << (3'h7 - code);
      boot_size = (raw > HALF_WORDS) ? HALF_WORDS : raw;
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] sleep_sync_r;
   logic [1:0] lvp_sync_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sleep_sync_r <= 2'h0;
         lvp_sync_r <= 2'h0;
      end else begin
         sleep_sync_r <= {sleep_sync_r[0], sleep_pin};
         lvp_sync_r <= {lvp_sync_r[0], lvp_session_pin};
      end
   end
   wire sleep_s = sleep_sync_r[1];
   wire lvp_act_s = lvp_sync_r[1];

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic loaded_r;
   logic [13:0] wd_word_r;
   logic [13:0] mem_word_r;
   logic sw_en_r;
   logic [2:0] sw_cs_r;
   logic [2:0] win_r;
   logic [4:0] ps_r;
   logic wait_r;
   logic [31:0] rdata_r;

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   wire [2:0] cs_code = wd_word_r[wmc_pkg::WD_CS_LSB +: 3];
   wire [2:0] ws_code = wd_word_r[wmc_pkg::WD_WS_LSB +: 3];
   wire [1:0] mode_code = wd_word_r[wmc_pkg::WD_MODE_LSB +: 2];
   wire [4:0] ps_code = wd_word_r[wmc_pkg::WD_PS_LSB +: 5];
   wire ws_sw = ws_code >= wmc_pkg::WS_FIRST_SW;
   wire ps_sw = ps_code == wmc_pkg::PS_AUTO;
   wire [2:0] cs_eff = (cs_code == wmc_pkg::CS_SOFTWARE) ? sw_cs_r : cs_code;
   // window and prescaler values loaded at reset release
   wire [2:0] win_load = ws_sw ? wmc_pkg::WS_OPEN_FULL : ws_code;
   wire [4:0] ps_load = ps_sw ? wmc_pkg::PS_AUTO_LOAD : ps_code;
   wire nv_ws_sw = nv_wd_word[wmc_pkg::WD_WS_LSB +: 3] >= wmc_pkg::WS_FIRST_SW;
   wire nv_ps_sw = nv_wd_word[wmc_pkg::WD_PS_LSB +: 5] == wmc_pkg::PS_AUTO;
   wire [2:0] nv_win = nv_ws_sw ? wmc_pkg::WS_OPEN_FULL : nv_wd_word[wmc_pkg::WD_WS_LSB +: 3];
   wire [4:0] nv_ps = nv_ps_sw ? wmc_pkg::PS_AUTO_LOAD : nv_wd_word[wmc_pkg::WD_PS_LSB +: 5];

   wire run_nxt = (mode_code == wmc_pkg::MODE_ALWAYS) |
                  ((mode_code == wmc_pkg::MODE_AWAKE) & ~sleep_s) |
                  ((mode_code == wmc_pkg::MODE_SOFTWARE) & sw_en_r);

   wire lvp_bit = mem_word_r[wmc_pkg::MEM_LVP];
   wire saf_en = ~mem_word_r[wmc_pkg::MEM_SAF_EN_N];
   wire boot_en = ~mem_word_r[wmc_pkg::MEM_BOOT_EN_N];
   wire [16:0] boot_nxt = boot_en ? boot_size(mem_word_r[wmc_pkg::MEM_BSIZE_LSB +: 3]) : 17'h0;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire req = (avs_read | avs_write) & loaded_r;
   wire wr_take = avs_write & loaded_r & ~wait_r;
   wire rd_sample = avs_read & loaded_r & wait_r;
   wire hit_mem = avs_address == wmc_pkg::OFS_MEM_CFG;
   wire hit_ctrl = avs_address == wmc_pkg::OFS_CTRL;
   wire hit_win = avs_address == wmc_pkg::OFS_WINDOW;
   wire hit_ps = avs_address == wmc_pkg::OFS_PRESCALE;
   wire [13:0] wdat = avs_writedata[13:0];
   wire erase = wr_take & hit_ctrl & avs_writedata[wmc_pkg::CTRL_ERASE];

   // sticky bits only move toward zero; size locked once the boot block exists
   wire [13:0] sticky_nxt = mem_word_r & wdat & wmc_pkg::MEM_STICKY_MASK;
   wire [13:0] size_nxt = (boot_en ? mem_word_r : wdat) & wmc_pkg::MEM_SIZE_MASK;
   // lvp may be set but not cleared while a low-voltage session runs
   wire lvp_nxt = lvp_act_s ? (lvp_bit | wdat[wmc_pkg::MEM_LVP]) : wdat[wmc_pkg::MEM_LVP];
   wire [13:0] mem_nxt = sticky_nxt | size_nxt | wmc_pkg::MEM_UNIMP_MASK |
                         (14'(lvp_nxt) << wmc_pkg::MEM_LVP);

   wire [31:0] status_word = {26'h0, ws_sw, ps_sw, ~ws_sw, sleep_s, lvp_act_s, wd_run};
   logic [31:0] rd_mux;
   always_comb begin
      unique case (avs_address)
         wmc_pkg::OFS_WD_CFG: rd_mux = {18'h0, wd_word_r | wmc_pkg::WD_UNIMP_MASK};
         wmc_pkg::OFS_MEM_CFG: rd_mux = {18'h0, mem_word_r | wmc_pkg::MEM_UNIMP_MASK};
         wmc_pkg::OFS_CTRL: rd_mux = {25'h0, sw_cs_r, 3'h0, sw_en_r};
         wmc_pkg::OFS_WINDOW: rd_mux = {29'h0, win_r};
         wmc_pkg::OFS_PRESCALE: rd_mux = {27'h0, ps_r};
         wmc_pkg::OFS_STATUS: rd_mux = status_word;
         wmc_pkg::OFS_BOOT: rd_mux = {15'h0, boot_region_words};
         default: rd_mux = 32'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // bus handshake: one wait cycle, then release for one cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         wait_r <= ~(req & wait_r);
         if (rd_sample) begin
            rdata_r <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration capture at reset release
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         loaded_r <= 1'b0;
         wd_word_r <= wmc_pkg::ERASED_WORD;
         mem_word_r <= wmc_pkg::ERASED_WORD;
      end else if (!loaded_r) begin
         loaded_r <= 1'b1;
         wd_word_r <= nv_wd_word | wmc_pkg::WD_UNIMP_MASK;
         mem_word_r <= nv_mem_word | wmc_pkg::MEM_UNIMP_MASK;
      end else if (erase) begin
         mem_word_r <= wmc_pkg::ERASED_WORD;
      end else if (wr_take & hit_mem) begin
         mem_word_r <= mem_nxt;
      end
   end

   // ----------------------------------------------------------------
   // software-owned watchdog settings
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sw_en_r <= 1'b0;
         sw_cs_r <= 3'h0;
         win_r <= wmc_pkg::WS_OPEN_FULL;
         ps_r <= wmc_pkg::PS_AUTO_LOAD;
      end else if (!loaded_r) begin
         win_r <= nv_win;
         ps_r <= nv_ps;
      end else begin
         if (wr_take & hit_ctrl) begin
            sw_en_r <= avs_writedata[wmc_pkg::CTRL_SW_EN];
            sw_cs_r <= avs_writedata[wmc_pkg::CTRL_CS_LSB +: 3];
         end
         if (wr_take & hit_win & ws_sw) begin
            win_r <= avs_writedata[2:0];
         end
         if (wr_take & hit_ps & ps_sw) begin
            ps_r <= avs_writedata[4:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wd_run <= 1'b0;
         wd_clock_source_sel <= 3'h0;
         wd_runtime_window <= wmc_pkg::WS_OPEN_FULL;
         wd_runtime_prescale <= wmc_pkg::PS_AUTO_LOAD;
         wd_keyed_access_req <= 1'b0;
         low_voltage_prog_enable <= 1'b0;
         master_clear_forced <= 1'b0;
         storage_area_present <= 1'b0;
         storage_area_wp <= 1'b0;
         config_region_wp <= 1'b0;
         boot_region_wp <= 1'b0;
         app_region_wp <= 1'b0;
         boot_region_words <= 17'h0;
      end else if (loaded_r) begin
         wd_run <= run_nxt;
         wd_clock_source_sel <= cs_eff;
         wd_runtime_window <= win_r;
         wd_runtime_prescale <= ps_r;
         wd_keyed_access_req <= ~ws_sw;
         low_voltage_prog_enable <= lvp_bit;
         master_clear_forced <= lvp_bit;
         storage_area_present <= saf_en;
         storage_area_wp <= saf_en & ~mem_word_r[wmc_pkg::MEM_SAF_WP];
         config_region_wp <= ~mem_word_r[wmc_pkg::MEM_CFG_WP];
         boot_region_wp <= boot_en & ~mem_word_r[wmc_pkg::MEM_BOOT_WP];
         app_region_wp <= ~mem_word_r[wmc_pkg::MEM_APP_WP];
         boot_region_words <= boot_nxt;
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence mem_wr_s;
      wr_take & hit_mem & ~erase;
   endsequence

   lvp_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      (mem_wr_s and (lvp_act_s & lvp_bit)) |=> lvp_bit)
      else $error("lvp cleared during low-voltage session");
   sticky_bits_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & ~erase & ~mem_word_r[wmc_pkg::MEM_APP_WP]) |=> ~mem_word_r[wmc_pkg::MEM_APP_WP])
      else $error("sticky protection bit returned to one");
   size_lock_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & ~erase & boot_en) |=> $stable(mem_word_r[2:0]))
      else $error("boot size changed while block enabled");
   prescale_auto_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(loaded_r) & ps_sw |-> ps_r == wmc_pkg::PS_AUTO_LOAD)
      else $error("prescaler not loaded with default code");
   prescale_lock_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & ~ps_sw) |=> ps_r == ps_code)
      else $error("locked prescaler differs from configured code");
   window_open_a: assert property (@(posedge clock) disable iff (!rst_n)
      ($rose(loaded_r) & ws_sw) |-> win_r == wmc_pkg::WS_OPEN_FULL)
      else $error("window not fully open after load");
   window_lock_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & ~ws_sw) |=> (win_r == ws_code) & wd_keyed_access_req)
      else $error("fixed window not held");
   sw_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & mode_code == wmc_pkg::MODE_SOFTWARE) |=> wd_run == $past(sw_en_r))
      else $error("watchdog run does not follow software enable");
   mode_off_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & mode_code == wmc_pkg::MODE_OFF) |=> ~wd_run)
      else $error("watchdog runs while disabled");
   unimp_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_sample & avs_address == wmc_pkg::OFS_WD_CFG) |=> avs_readdata[7] & ~avs_waitrequest)
      else $error("unimplemented bit read as zero");
   boot_half_a: assert property (@(posedge clock) disable iff (!rst_n)
      boot_region_words <= HALF_WORDS)
      else $error("boot block larger than half memory");
   bus_answer_a: assert property (@(posedge clock) disable iff (!rst_n)
      (req & wait_r) |=> ~avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");
   // the capture path reads the raw word, the decode path the latched copy; both must agree
   load_match_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(loaded_r) |-> (win_r == win_load) && (ps_r == ps_load))
      else $error("runtime window or prescaler differs from captured word");
   clock_src_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & (cs_code != wmc_pkg::CS_SOFTWARE)) |=> wd_clock_source_sel == $past(cs_code))
      else $error("clock source differs from configured code");
   mode_always_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & (mode_code == wmc_pkg::MODE_ALWAYS)) |=> wd_run)
      else $error("watchdog stopped in always-on mode");
   sleep_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & (mode_code == wmc_pkg::MODE_AWAKE) & sleep_s) |=> ~wd_run)
      else $error("watchdog runs during sleep in awake mode");
   master_clear_pin_force_a: assert property (@(posedge clock) disable iff (!rst_n)
      loaded_r |=> (master_clear_forced == $past(lvp_bit)) && (low_voltage_prog_enable == $past(lvp_bit)))
      else $error("master clear not forced by low-voltage programming");
   saf_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & mem_word_r[wmc_pkg::MEM_SAF_EN_N]) |=> ~storage_area_wp & ~storage_area_present)
      else $error("absent storage area reported protected");
   boot_off_a: assert property (@(posedge clock) disable iff (!rst_n)
      (loaded_r & mem_word_r[wmc_pkg::MEM_BOOT_EN_N]) |=> (boot_region_words == 17'h0) & ~boot_region_wp)
      else $error("disabled boot block has size or protection");
endmodule

// *** verification/wmc_prog_model.sv ***
// Purpose: low-voltage programmer standing on the far side of the block
// Assumes: the bench asks for a programming session by a level request
// Notes: session pin is asynchronous at the block, so it moves on our edge here
`timescale 1ns/1ns
module wmc_prog_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // request from the bench, session pin to the block
   input wire logic session_req,
   output logic lvp_session_pin
);
   // the programmer never counts on clearing the lvp bit while in session
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         lvp_session_pin <= 1'b0;
      else
         lvp_session_pin <= session_req;
   end
endmodule

// *** verification/wmc_decode_tb.sv ***
// Purpose: self-checking bench for the configuration word decode block
// Assumes: the bus answers when ready, outputs settle a few cycles after a write
// Notes: random configuration words plus a fixed table of corner codes
`timescale 1ns/1ns
module wmc_decode_tb;
   localparam int MEMW = 8192;
   localparam logic [4:0] PST [8] = '{5'h00, 5'h12, 5'h13, 5'h1e, 5'h1f, 5'h0b, 5'h05, 5'h1f};
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [13:0] nv_wd_word = 14'h3fff;
   logic [13:0] nv_mem_word = 14'h3fff;
   logic sleep_pin = 1'b0;
   logic session_req = 1'b0;
   logic lvp_session_pin;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic wd_run, wd_keyed_access_req, low_voltage_prog_enable, master_clear_forced;
   logic [2:0] wd_clock_source_sel, wd_runtime_window;
   logic [4:0] wd_runtime_prescale;
   logic storage_area_present, storage_area_wp, config_region_wp, boot_region_wp, app_region_wp;
   logic [16:0] boot_region_words;
   logic [12:0] wd_seen;
   logic [23:0] mem_seen;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed = 90463;
   assign wd_seen = {wd_clock_source_sel, wd_runtime_window, wd_runtime_prescale, wd_keyed_access_req, wd_run};
   assign mem_seen = {low_voltage_prog_enable, master_clear_forced, storage_area_present, storage_area_wp,
      config_region_wp, boot_region_wp, app_region_wp, boot_region_words};
   wmc_decode #(.USER_MEM_WORDS(MEMW)) wmc_decode_i (.clock(clock), .rst_n(rst_n), .nv_wd_word(nv_wd_word),
      .nv_mem_word(nv_mem_word), .sleep_pin(sleep_pin), .lvp_session_pin(lvp_session_pin),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wd_run(wd_run),
      .wd_clock_source_sel(wd_clock_source_sel), .wd_runtime_window(wd_runtime_window),
      .wd_runtime_prescale(wd_runtime_prescale), .wd_keyed_access_req(wd_keyed_access_req),
      .low_voltage_prog_enable(low_voltage_prog_enable), .master_clear_forced(master_clear_forced),
      .storage_area_present(storage_area_present), .storage_area_wp(storage_area_wp),
      .config_region_wp(config_region_wp), .boot_region_wp(boot_region_wp), .app_region_wp(app_region_wp),
      .boot_region_words(boot_region_words));
   wmc_prog_model wmc_prog_model_i (.clock(clock), .rst_n(rst_n), .session_req(session_req),
      .lvp_session_pin(lvp_session_pin));
   initial begin
      forever #5 clock = ~clock;
   end
   // ---------------------------------------------
   // expectations
   // ---------------------------------------------
   function automatic logic [12:0] wexp(input logic [13:0] w, input logic [2:0] ccs, input logic sw,
      input logic [2:0] wv, input logic [4:0] pv, input logic sl);
      logic run;
      case (w[6:5])
         2'h3: run = 1'b1;
         2'h2: run = !sl;
         2'h1: run = sw;
         default: run = 1'b0;
      endcase
      return {(w[13:11] == 3'h7) ? ccs : w[13:11], (w[10:8] >= 3'h6) ? wv : w[10:8],
         (w[4:0] == 5'h1f) ? pv : w[4:0], w[10:8] < 3'h6, run};
   endfunction
   function automatic logic [23:0] mexp(input logic [13:0] m);
      logic [16:0] w;
      case (m[2:0])
         3'h7: w = 17'h00200;
         3'h6: w = 17'h00400;
         3'h5: w = 17'h00800;
         3'h4: w = 17'h01000;
         default: w = 17'h02000;
      endcase
      if (w > 17'(MEMW / 2))
         w = 17'(MEMW / 2);
      return {m[13], m[13], !m[4], !m[4] & !m[11], !m[9], !m[3] & !m[8], !m[7], m[3] ? 17'h0 : w};
   endfunction
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // entered just after a rising edge; waitrequest and read data are taken at the edge where waitrequest is low
   task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [31:0] exp);
      logic w;
      logic [31:0] q;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      w = 1'b1;
      q = 32'h0;
      while (w !== 1'b0) begin
         @(posedge clock);
         w = avs_waitrequest;
         q = avs_readdata;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (!wr)
         chk(q, exp);
      @(posedge clock);
   endtask
   task automatic reboot(input logic [13:0] wd, input logic [13:0] mem);
      rst_n <= 1'b0;
      nv_wd_word <= wd;
      nv_mem_word <= mem;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
   task automatic mchk(input logic [13:0] m);
      repeat (3) @(posedge clock);
      chk(32'(mem_seen), 32'(mexp(m)));
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      logic [13:0] wd, mem;
      logic [31:0] r;
      logic [4:0] i;
      for (i = 0; i < 24; i++) begin
         wd = 14'($random(seed));
         mem = 14'($random(seed));
         r = $random(seed);
         if (i < 8) begin
            wd[13:5] = {i[2:0], i[2:0], 1'b1, i[1:0]};
            wd[4:0] = PST[i[2:0]];
            mem[3:0] = {1'b0, i[2:0]};
         end
         sleep_pin <= r[0];
         reboot(wd, mem);
         chk(32'(wd_seen), 32'(wexp(wd, 3'h0, 1'b0, 3'h7, 5'h0b, r[0])));
         mchk(mem);
         xfer(1'b0, wmc_pkg::OFS_WD_CFG, 32'h0, {18'h0, wd | wmc_pkg::WD_UNIMP_MASK});
         xfer(1'b0, wmc_pkg::OFS_MEM_CFG, 32'h0, {18'h0, mem | wmc_pkg::MEM_UNIMP_MASK});
         xfer(1'b1, wmc_pkg::OFS_CTRL, {25'h0, r[6:4], 3'h0, r[1]}, 32'h0);
         xfer(1'b1, wmc_pkg::OFS_WINDOW, {29'h0, r[10:8]}, 32'h0);
         xfer(1'b1, wmc_pkg::OFS_PRESCALE, {27'h0, r[20:16]}, 32'h0);
         repeat (3) @(posedge clock);
         chk(32'(wd_seen), 32'(wexp(wd, r[6:4], r[1], r[10:8], r[20:16], r[0])));
      end
      reboot(14'h3fff, 14'h3fff);
      xfer(1'b1, 5'h1c, 32'hffffffff, 32'h0);
      xfer(1'b0, 5'h1c, 32'h0, 32'h0);
      xfer(1'b1, wmc_pkg::OFS_WD_CFG, 32'h0, 32'h0);
      xfer(1'b0, wmc_pkg::OFS_WD_CFG, 32'h0, 32'h00003fff);
      xfer(1'b1, wmc_pkg::OFS_MEM_CFG, 32'h3ffd, 32'h0);
      xfer(1'b0, wmc_pkg::OFS_MEM_CFG, 32'h0, 32'h00003ffd);
      xfer(1'b1, wmc_pkg::OFS_MEM_CFG, 32'h3ff5, 32'h0);
      mchk(14'h3ff5);
      // sticky enable cannot go back to one, and the size is now frozen
      xfer(1'b1, wmc_pkg::OFS_MEM_CFG, 32'h3ffa, 32'h0);
      xfer(1'b0, wmc_pkg::OFS_MEM_CFG, 32'h0, 32'h00003ff5);
      session_req <= 1'b1;
      repeat (5) @(posedge clock);
      xfer(1'b1, wmc_pkg::OFS_MEM_CFG, 32'h0, 32'h0);
      xfer(1'b0, wmc_pkg::OFS_MEM_CFG, 32'h0, 32'h00003465);
      mchk(14'h3465);
      session_req <= 1'b0;
      repeat (5) @(posedge clock);
      xfer(1'b1, wmc_pkg::OFS_MEM_CFG, 32'h0, 32'h0);
      xfer(1'b0, wmc_pkg::OFS_MEM_CFG, 32'h0, 32'h00001465);
      mchk(14'h1465);
      xfer(1'b1, wmc_pkg::OFS_CTRL, 32'h2, 32'h0);
      xfer(1'b0, wmc_pkg::OFS_MEM_CFG, 32'h0, 32'h00003fff);
      mchk(14'h3fff);
      test_done;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         chk(32'h1, 32'h0);
         test_done;
      end
   end
endmodule
